// >>> common/mlfr_pkg.sv
// Constants and types of the multi-line fast read engine.
// Assumes a serial flash link with chip select, serial clock and four data lines.
// Behaviour
// - Quad-output read opcode is taken only with quad enable set; data on four lines.
// - Quad-output read inserts eight dummy clocks after the 24-bit address.
// - Dual address/data read moves address and data over two lines.
// - Dual read: eight-bit continuation byte follows the address, before data.
// - Only the continuation upper nibble matters; lower nibble is ignored.
// - Upper nibble A: next dual read frame starts with the address, no opcode.
// - Any other upper nibble: next frame expects a full opcode again.
// - A mode reset clears the stored continuation; full opcodes follow. Here it acts on the fifth serial clock edge; a mode byte ending then wins.
// - Quad address/data read uses four lines after the opcode; opcode on one line unless four-wire mode; needs quad enable.
// - Quad read ending with nibble A: next quad read starts with address.
// - A prior wrap setting enables or disables wrap for quad address/data reads.
// - With wrap, address wraps inside its aligned 8/16/32/64-byte section.
// - Four-wire mode: quad read dummy count is 4, 6 or 8 from two bits.
// - Power-up or software reset returns the four-wire dummy count to four.
// - Four-wire mode: continuation works; mode clocks count toward dummy clocks.
// - Four-wire mode: quad address/data read never wraps.
// - Address bits sampled on rising edges, data driven on falling edges.
// - Address advances by one after each data byte while clocking continues.
package mlfr_pkg;

  // Opcodes handled here
  localparam logic [7:0] OPC_QUAD_OUT  = 8'h6B;
  localparam logic [7:0] OPC_DUAL_IO   = 8'hBB;
  localparam logic [7:0] OPC_QUAD_IO   = 8'hEB;

  // Continuation nibble that keeps opcode-less reads
  localparam logic [3:0] CONT_KEEP_NIBBLE = 4'hA;

  // Array model size
  localparam int MEM_AW = 10;
  localparam int ADDR_W = 24;

  // Phase lengths in serial clocks
  localparam logic [5:0] OPC_CLK_SINGLE     = 6'h08;
  localparam logic [5:0] OPC_CLK_QUAD       = 6'h02;
  localparam logic [5:0] ADDR_CLK_SINGLE    = 6'h18;
  localparam logic [5:0] ADDR_CLK_DUAL      = 6'h0C;
  localparam logic [5:0] ADDR_CLK_QUAD      = 6'h06;
  localparam logic [5:0] MODE_CLK_DUAL      = 6'h04;
  localparam logic [5:0] MODE_CLK_QUAD      = 6'h02;
  localparam logic [5:0] DUMMY_CLK_QUAD_OUT = 6'h08;
  localparam logic [5:0] DUMMY_CLK_QUAD_IO  = 6'h04;
  localparam logic [5:0] BYTE_CLK_DUAL      = 6'h04;
  localparam logic [5:0] BYTE_CLK_QUAD      = 6'h02;

  // Four-wire mode dummy counts by read parameter bits {P5,P4}
  localparam logic [5:0] QPI_DUMMY_4 = 6'h04;
  localparam logic [5:0] QPI_DUMMY_6 = 6'h06;
  localparam logic [5:0] QPI_DUMMY_8 = 6'h08;
  localparam logic [1:0] DUMMY_SEL_RESET = 2'h0;

  // Wrap section masks by wrap length code
  localparam logic [23:0] WRAP_MASK_8  = 24'h000007;
  localparam logic [23:0] WRAP_MASK_16 = 24'h00000F;
  localparam logic [23:0] WRAP_MASK_32 = 24'h00001F;
  localparam logic [23:0] WRAP_MASK_64 = 24'h00003F;

  // Frame sequencer states
  typedef enum logic [5:0] {
    ST_OPC    = 6'h01,
    ST_ADDR   = 6'h02,
    ST_MODE   = 6'h04,
    ST_DUMMY  = 6'h08,
    ST_DATA   = 6'h10,
    ST_IGNORE = 6'h20
  } mlfr_state_type;

endpackage : mlfr_pkg

// >>> rtl/mlfr_sync.sv
// Two-flop synchroniser for quasi-static levels.
// Assumes each bit changes rarely and is stable for several destination clocks.
`timescale 1ns/100ps
`default_nettype none
module mlfr_sync
#(
  parameter int W = 1
)
(
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);

  logic [W-1:0] meta;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta  <= '0;
      q_out <= '0;
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule : mlfr_sync
`default_nettype wire

// >>> rtl/mlfr_mem.sv
// Byte array with a system-clock write port and a registered link-clock read port.
// Assumes writes and reads of one address never overlap in time.
`timescale 1ns/100ps
`default_nettype none
module mlfr_mem
(
  input  wire logic                      wclk_in,
  input  wire logic                      we_in,
  input  wire logic [mlfr_pkg::MEM_AW-1:0] waddr_in,
  input  wire logic [7:0]                wdata_in,
  input  wire logic                      rclk_in,
  input  wire logic [mlfr_pkg::MEM_AW-1:0] raddr_in,
  output var  logic [7:0]                rdata_out
);
  import mlfr_pkg::*;

  logic [7:0] array [0:(1<<MEM_AW)-1];

  // Loading from the system side
  always_ff @(posedge wclk_in)
  begin
    if (we_in)
      array[waddr_in] <= wdata_in;
  end

  // Registered read on the link clock
  always_ff @(posedge rclk_in)
  begin
    rdata_out <= array[raddr_in];
  end

endmodule : mlfr_mem
`default_nettype wire

// >>> rtl/mlfr_engine.sv
// Device side of the dual/quad fast read instructions with continuation mode and wrap.
// Assumes the host drives chip select and serial clock; the serial clock stops between frames.
`timescale 1ns/100ps
`default_nettype none
module mlfr_engine
(
  input  wire logic                        CLOCK_IN,
  input  wire logic                        RST_N_IN,
  input  wire logic                        SCK_IN,
  input  wire logic                        CS_N_IN,
  input  wire logic [3:0]                  IO_IN,
  output var  logic [3:0]                  IO_OUT,
  output var  logic [3:0]                  IO_OE_OUT,
  input  wire logic                        QUAD_ENABLE_IN,
  input  wire logic                        FOUR_WIRE_MODE_IN,
  input  wire logic                        WRAP_ENABLE_IN,
  input  wire logic [1:0]                  WRAP_LEN_IN,
  input  wire logic                        PARAM_WR_IN,
  input  wire logic [1:0]                  PARAM_IN,
  input  wire logic                        SOFT_RESET_IN,
  input  wire logic                        MODE_RESET_IN,
  input  wire logic                        MEM_WE_IN,
  input  wire logic [mlfr_pkg::MEM_AW-1:0] MEM_WADDR_IN,
  input  wire logic [7:0]                  MEM_WDATA_IN,
  output var  logic                        CONT_ACTIVE_OUT,
  output var  logic [1:0]                  DUMMY_SEL_OUT
);
  import mlfr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Lines used for incoming bits in a phase
  function automatic logic [2:0] in_lanes(input mlfr_state_type st, input logic [7:0] opc, input logic four);
    logic [2:0] n;
    n = 3'h1;
    if (st == ST_OPC)
      n = four ? 3'h4 : 3'h1;
    else if (opc == OPC_DUAL_IO)
      n = 3'h2;
    else if (opc == OPC_QUAD_IO)
      n = 3'h4;
    return n;
  endfunction : in_lanes

  // Shift received bits in, highest line first
  function automatic logic [23:0] shift_in(input logic [23:0] sr, input logic [3:0] io, input logic [2:0] n);
    logic [23:0] r;
    r = {sr[22:0], io[0]};
    if (n == 3'h2)
      r = {sr[21:0], io[1:0]};
    else if (n == 3'h4)
      r = {sr[19:0], io[3:0]};
    return r;
  endfunction : shift_in

  // Four-wire dummy count from read parameter bits
  function automatic logic [5:0] qpi_dummy(input logic [1:0] sel);
    logic [5:0] d;
    d = QPI_DUMMY_8;
    if (sel == 2'h0)
      d = QPI_DUMMY_4;
    else if (sel == 2'h1)
      d = QPI_DUMMY_6;
    return d;
  endfunction : qpi_dummy

  // Clocks in the current phase
  function automatic logic [5:0] phase_len(input mlfr_state_type st, input logic [7:0] opc, input logic four,
                                           input logic [1:0] sel);
    logic [5:0] l;
    l = 6'h01;
    case (st)
      ST_OPC:   l = four ? OPC_CLK_QUAD : OPC_CLK_SINGLE;
      ST_ADDR:  l = (opc == OPC_QUAD_OUT) ? ADDR_CLK_SINGLE : (opc == OPC_DUAL_IO) ? ADDR_CLK_DUAL : ADDR_CLK_QUAD;
      ST_MODE:  l = (opc == OPC_DUAL_IO) ? MODE_CLK_DUAL : MODE_CLK_QUAD;
      ST_DUMMY: l = (opc == OPC_QUAD_OUT) ? DUMMY_CLK_QUAD_OUT
                  : four ? 6'(qpi_dummy(sel) - MODE_CLK_QUAD) : DUMMY_CLK_QUAD_IO;
      ST_DATA:  l = (opc == OPC_DUAL_IO) ? BYTE_CLK_DUAL : BYTE_CLK_QUAD;
      default:  l = 6'h01;
    endcase
    return l;
  endfunction : phase_len

  // Next byte address, optionally wrapping inside its section
  function automatic logic [23:0] next_read_addr(input logic [23:0] a, input logic wrap, input logic [1:0] len);
    logic [23:0] m;
    logic [23:0] inc;
    m   = (len == 2'h0) ? WRAP_MASK_8 : (len == 2'h1) ? WRAP_MASK_16 : (len == 2'h2) ? WRAP_MASK_32 : WRAP_MASK_64;
    inc = a + 24'h000001;
    return wrap ? ((a & ~m) | (inc & m)) : inc;
  endfunction : next_read_addr

  ////////////////////////////////////////////////////////////////////////////
  // System clock side: read parameters, mode reset request, status

  logic [1:0] dummy_sel;
  logic       mode_rst_tgl;
  logic       cont_valid;

  // Software reset wins over a parameter write and restores four clocks
  wire  [1:0] next_dummy_sel    = SOFT_RESET_IN ? DUMMY_SEL_RESET : PARAM_WR_IN ? PARAM_IN : dummy_sel;
  // Mode reset travels as a toggle, so a one-cycle pulse survives a stopped serial clock
  wire        next_mode_rst_tgl = mode_rst_tgl ^ MODE_RESET_IN;

  // Read parameter bits and mode reset request
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      dummy_sel    <= DUMMY_SEL_RESET;
      mode_rst_tgl <= 1'b0;
    end
    else
    begin
      dummy_sel    <= next_dummy_sel;
      mode_rst_tgl <= next_mode_rst_tgl;
    end
  end

  assign DUMMY_SEL_OUT = dummy_sel;

  // Continuation status brought back to the system clock
  mlfr_sync #(.W(1)) u_cont_sync
  (
    .clk_in   (CLOCK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (cont_valid),
    .q_out    (CONT_ACTIVE_OUT)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Settings carried into the serial clock domain

  logic [7:0] cfg_s;
  logic       qe_s;
  logic       four_s;
  logic       wrap_en_s;
  logic [1:0] wrap_len_s;
  logic [1:0] dsel_s;
  logic       tgl_s;
  logic [7:0] cfg_prev;
  logic [7:0] cfg_hold;

  mlfr_sync #(.W(8)) u_cfg_sync
  (
    .clk_in   (SCK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     ({QUAD_ENABLE_IN, FOUR_WIRE_MODE_IN, WRAP_ENABLE_IN, WRAP_LEN_IN, dummy_sel, mode_rst_tgl}),
    .q_out    (cfg_s)
  );

  // Each bit is synchronised on its own; a word is taken only after two equal samples,
  // so bits that resolve on different edges never form a value that nobody wrote.
  // Cost: settings reach the frame logic after four serial clock edges, a mode reset acts on the fifth.
  wire       cfg_steady    = (cfg_s == cfg_prev);
  wire [7:0] next_cfg_hold = cfg_steady ? cfg_s : cfg_hold;

  // Sample history and the accepted settings word
  always_ff @(posedge SCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      cfg_prev <= 8'h00;
      cfg_hold <= 8'h00;
    end
    else
    begin
      cfg_prev <= cfg_s;
      cfg_hold <= next_cfg_hold;
    end
  end

  assign {qe_s, four_s, wrap_en_s, wrap_len_s, dsel_s, tgl_s} = cfg_hold;

  ////////////////////////////////////////////////////////////////////////////
  // Frame decode on rising serial clock edges

  mlfr_state_type state;
  mlfr_state_type next_state;
  logic [5:0]     cnt;
  logic [23:0]    sr;
  logic [7:0]     op;
  logic [23:0]    addr;
  logic [7:0]     cont_op;
  logic           tgl_seen;
  logic [7:0]     mem_q;
  logic [7:0]     out_byte;

  wire            frame_rst_n = RST_N_IN & ~CS_N_IN;
  wire            skip_opc    = (state == ST_OPC) && (cnt == 6'h00) && cont_valid;
  wire mlfr_state_type cur_state = skip_opc ? ST_ADDR : state;
  wire [7:0]      cur_op      = skip_opc ? cont_op : op;
  wire [2:0]      lanes       = in_lanes(cur_state, cur_op, four_s);
  wire [23:0]     next_sr     = shift_in(sr, IO_IN, lanes);
  wire [5:0]      len         = phase_len(cur_state, cur_op, four_s, dsel_s);
  wire            last        = (cnt == 6'(len - 6'h01));
  wire [7:0]      opc_rx      = next_sr[7:0];
  wire            opc_ok      = ((opc_rx == OPC_QUAD_OUT) && qe_s && !four_s)
                              || ((opc_rx == OPC_DUAL_IO) && !four_s)
                              || ((opc_rx == OPC_QUAD_IO) && qe_s);
  wire            mode_keep   = (next_sr[7:4] == CONT_KEEP_NIBBLE);
  wire            wrap_on     = wrap_en_s && !four_s && (cur_op == OPC_QUAD_IO);
  wire            mode_rst    = (tgl_s != tgl_seen);
  wire            mode_end    = (cur_state == ST_MODE) && last;
  wire            data_dual   = (op == OPC_DUAL_IO);

  // Sequencer
  always_comb
  begin
    next_state = cur_state;
    case (cur_state)
      ST_OPC:    next_state = !last ? ST_OPC : opc_ok ? ST_ADDR : ST_IGNORE;
      ST_ADDR:   next_state = !last ? ST_ADDR : (cur_op == OPC_QUAD_OUT) ? ST_DUMMY : ST_MODE;
      ST_MODE:   next_state = !last ? ST_MODE : (cur_op == OPC_DUAL_IO) ? ST_DATA : ST_DUMMY;
      ST_DUMMY:  next_state = last ? ST_DATA : ST_DUMMY;
      ST_DATA:   next_state = ST_DATA;
      ST_IGNORE: next_state = ST_IGNORE;
      default:   next_state = ST_IGNORE;
    endcase
  end

  // Frame registers, cleared whenever chip select is high
  always_ff @(posedge SCK_IN or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      state <= ST_OPC;
      cnt   <= 6'h00;
      sr    <= 24'h000000;
      op    <= 8'h00;
      addr  <= 24'h000000;
    end
    else
    begin
      state <= next_state;
      cnt   <= (last || (cur_state == ST_IGNORE)) ? 6'h00 : 6'(cnt + 6'h01);
      sr    <= next_sr;
      op    <= (cur_state == ST_OPC && last) ? opc_rx : cur_op;
      if (cur_state == ST_ADDR && last)
        addr <= next_sr;
      else if (cur_state == ST_DATA && cnt == 6'h00)
        addr <= next_read_addr(addr, wrap_on, wrap_len_s);
    end
  end

  // Continuation state outlives the frame; a new mode byte beats a mode reset
  always_ff @(posedge SCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      cont_valid <= 1'b0;
      cont_op    <= 8'h00;
      tgl_seen   <= 1'b0;
    end
    else
    begin
      tgl_seen <= tgl_s;
      if (mode_end)
      begin
        cont_valid <= mode_keep;
        cont_op    <= cur_op;
      end
      else if (mode_rst)
        cont_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array read, one byte ahead of the output

  mlfr_mem u_mem
  (
    .wclk_in   (CLOCK_IN),
    .we_in     (MEM_WE_IN),
    .waddr_in  (MEM_WADDR_IN),
    .wdata_in  (MEM_WDATA_IN),
    .rclk_in   (SCK_IN),
    .raddr_in  (addr[MEM_AW-1:0]),
    .rdata_out (mem_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data drive on falling serial clock edges

  wire [7:0] out_src  = (cnt == 6'h00) ? mem_q : out_byte;
  wire [3:0] out_bits = data_dual ? {2'b00, out_src[7:6]} : out_src[7:4];
  wire [7:0] out_rest = data_dual ? {out_src[5:0], 2'b00} : {out_src[3:0], 4'h0};

  // Lines turn to outputs only in the data phase; host has released them
  always_ff @(negedge SCK_IN or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      IO_OUT    <= 4'h0;
      IO_OE_OUT <= 4'h0;
      out_byte  <= 8'h00;
    end
    else if (state == ST_DATA)
    begin
      IO_OUT    <= out_bits;
      IO_OE_OUT <= data_dual ? 4'h3 : 4'hF;
      out_byte  <= out_rest;
    end
    else
    begin
      IO_OUT    <= 4'h0;
      IO_OE_OUT <= 4'h0;
      out_byte  <= 8'h00;
    end
  end

endmodule : mlfr_engine
`default_nettype wire

// >>> test/mlfr_engine_properties.sv
// Checker of the multi-line fast read engine's ports.
// Assumes the bind below attaches it to every engine instance.
`timescale 1ns/100ps
`default_nettype none
module mlfr_engine_properties
(
  input wire logic       CLOCK_IN,
  input wire logic       RST_N_IN,
  input wire logic       SCK_IN,
  input wire logic       CS_N_IN,
  input wire logic [3:0] IO_OUT,
  input wire logic [3:0] IO_OE_OUT,
  input wire logic       PARAM_WR_IN,
  input wire logic [1:0] PARAM_IN,
  input wire logic       SOFT_RESET_IN,
  input wire logic [1:0] DUMMY_SEL_OUT
);
  // Frame opening and the quiet lead-in before any data
  sequence frame_open_s;
    $fell(CS_N_IN);
  endsequence
  sequence lines_quiet_s;
    (IO_OE_OUT == 4'h0) [*8];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  oe_legal_a: assert property (@(negedge SCK_IN) disable iff (!RST_N_IN)
    IO_OE_OUT inside {4'h0, 4'h3, 4'hF}) else $error("illegal enable set");
  undriven_zero_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (IO_OUT & ~IO_OE_OUT) == 4'h0) else $error("value on undriven line");
  cs_release_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    CS_N_IN |-> IO_OE_OUT == 4'h0) else $error("lines driven while deselected");
  oe_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    !CS_N_IN && !$past(CS_N_IN) && $past(IO_OE_OUT) != 4'h0 |-> IO_OE_OUT == $past(IO_OE_OUT))
    else $error("data drive dropped in frame");
  lead_in_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    frame_open_s |-> lines_quiet_s) else $error("data too early in frame");
  param_load_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    PARAM_WR_IN && !SOFT_RESET_IN |=> DUMMY_SEL_OUT == $past(PARAM_IN)) else $error("parameter not loaded");
  soft_reset_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    SOFT_RESET_IN |=> DUMMY_SEL_OUT == 2'h0) else $error("dummy selection not reset");
  sel_steady_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    !PARAM_WR_IN && !SOFT_RESET_IN |=> $stable(DUMMY_SEL_OUT)) else $error("dummy selection moved");
endmodule : mlfr_engine_properties
bind mlfr_engine mlfr_engine_properties mlfr_engine_properties_i (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
  .SCK_IN(SCK_IN), .CS_N_IN(CS_N_IN), .IO_OUT(IO_OUT), .IO_OE_OUT(IO_OE_OUT), .PARAM_WR_IN(PARAM_WR_IN),
  .PARAM_IN(PARAM_IN), .SOFT_RESET_IN(SOFT_RESET_IN), .DUMMY_SEL_OUT(DUMMY_SEL_OUT));
`default_nettype wire

// >>> test/mlfr_host.sv
// Host flash controller model: select, serial clock and data lines.
// Assumes the bench resolves the lines and feeds them back on io_in.
`timescale 1ns/100ps
`default_nettype none
module mlfr_host
(
  output var  logic       sck_out,
  output var  logic       cs_n_out,
  output var  logic [3:0] io_out,
  output var  logic [3:0] io_oe_out,
  input  wire logic [3:0] io_in,
  output var  logic       got_out,
  output var  logic [7:0] byte_out
);
  logic [3:0] sh;
  // Idle levels: clock low, deselected, lines released
  initial
  begin
    {sck_out, cs_n_out, got_out} = 3'h2;
    {io_out, io_oe_out} = 8'h0;
    byte_out = 8'h0;
  end
  // One clock: drive in low phase, sample at rise, release before the fall
  task automatic clk(input logic [3:0] v, input logic [3:0] oe);
    io_out = v;
    io_oe_out = oe;
    #24 sck_out = 1'b1;
    sh = io_in;
    #12 io_oe_out = 4'h0;
    #12 sck_out = 1'b0;
  endtask : clk
  // Shifts n bits out, w lines a clock, top line most significant
  task automatic send(input logic [31:0] v, input int n, input int w);
    logic [3:0] m;
    m = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
    for (int i = n - w; i >= 0; i -= w)
      clk(4'(v >> i) & m, m);
  endtask : send
  // Collects nb bytes over w lines
  task automatic rd(input int nb, input int w);
    logic [7:0] b;
    b = 8'h0;
    for (int k = 1; k <= nb * 8 / w; k++)
    begin
      clk(4'h0, 4'h0);
      b = (w == 4) ? {b[3:0], sh} : {b[5:0], sh[1:0]};
      if (k * w % 8 == 0)
      begin
        byte_out = b;
        got_out = ~got_out;
      end
    end
  endtask : rd
  // Opens a frame: opcode, address, mode byte, dummies, data
  task automatic frame(input logic [7:0] op, input int ow, input logic [23:0] a, input int aw, input int mw,
                       input logic [7:0] md, input int nd, input int nb, input int dw);
    cs_n_out = 1'b0;
    #24;
    if (ow > 0)
      send(op, 8, ow);
    send(a, 24, aw);
    if (mw > 0)
      send(md, 8, mw);
    repeat (nd) clk(4'h0, 4'h0);
    rd(nb, dw);
  endtask : frame
  // Closes the frame; the clock stands still meanwhile
  task automatic stop();
    #24 cs_n_out = 1'b1;
    #60;
  endtask : stop
endmodule : mlfr_host
`default_nettype wire

// >>> test/mlfr_engine_test.sv
// Self-checking bench of the multi-line fast read engine.
// Assumes the host model runs the link; expected bytes are queued before each read.
`timescale 1ns/100ps
`default_nettype none
module mlfr_engine_test;
  import mlfr_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tog = 1'b0;
  logic        sck, cs_n, got, qe, fw, wen, pwr, srst, mrst, mwe, cont;
  logic [3:0]  host_io, host_oe, dev_io, dev_oe, line;
  logic [1:0]  wlen, par, dsel;
  logic [9:0]  mwa;
  logic [7:0]  mwd, gb;
  logic [7:0]  mem [1024];
  logic [7:0]  ops [4] = '{8'h6B, 8'hEB, 8'h6B, 8'hBB};
  logic [7:0]  q [$];
  logic [23:0] a;
  int          failures = 0;
  int          n_tests = 0;
  int          n;
  integer      seed = 32'h8C01B15E;
  ////////////////////////////////////////////////////////////////////////////
  // Clock, changing pattern on released lines, line resolution
  initial
    forever #2.5 clk = ~clk;
  always @(negedge sck) tog <= ~tog;
  assign line = (dev_oe & dev_io) | (host_oe & host_io) | (~dev_oe & ~host_oe & {4{tog}});
  mlfr_engine mlfr_engine_i (.CLOCK_IN(clk), .RST_N_IN(rst_n), .SCK_IN(sck), .CS_N_IN(cs_n), .IO_IN(line),
    .IO_OUT(dev_io), .IO_OE_OUT(dev_oe), .QUAD_ENABLE_IN(qe), .FOUR_WIRE_MODE_IN(fw), .WRAP_ENABLE_IN(wen),
    .WRAP_LEN_IN(wlen), .PARAM_WR_IN(pwr), .PARAM_IN(par), .SOFT_RESET_IN(srst), .MODE_RESET_IN(mrst),
    .MEM_WE_IN(mwe), .MEM_WADDR_IN(mwa), .MEM_WDATA_IN(mwd), .CONT_ACTIVE_OUT(cont), .DUMMY_SEL_OUT(dsel));
  mlfr_host mlfr_host_i (.sck_out(sck), .cs_n_out(cs_n), .io_out(host_io), .io_oe_out(host_oe),
    .io_in(line), .got_out(got), .byte_out(gb));
  ////////////////////////////////////////////////////////////////////////////
  // Comparison, expectation and verdict helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic note(input logic [23:0] b, input int k, input logic [23:0] m);
    repeat (k)
    begin
      q.push_back(mem[b[9:0]]);
      b = (b & ~m) | ((b + 24'h1) & m);
    end
  endtask : note
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // Ignored frame that lets changed settings cross into the link domain
  task automatic idle();
    mlfr_host_i.frame(8'h00, fw ? 4 : 1, 24'h0, 4, 0, 8'h00, 0, 0, 4);
    mlfr_host_i.stop();
  endtask : idle
  task automatic setp(input logic [1:0] p, input logic s);
    @(negedge clk);
    {par, pwr, srst} = {p, 1'b1, s};
    @(negedge clk);
    {pwr, srst} = 2'h0;
    check({6'h0, dsel}, s ? 8'h0 : {6'h0, p});
  endtask : setp
  // Three reads whose mode bytes keep, keep, then drop continuation
  task automatic chain(input logic [7:0] op, input int ow, input int w, input int nd);
    logic [7:0] md [3] = '{8'hA5, 8'hAF, 8'h5A};
    logic       c;
    c = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      a = 24'($random(seed));
      note(a, 3, 24'hFFFFFF);
      mlfr_host_i.frame(op, c ? 0 : ow, a, w, w, md[i], nd, 3, w);
      mlfr_host_i.stop();
      c = md[i][7:4] == CONT_KEEP_NIBBLE;
      repeat (8) @(negedge clk);
      check({7'h0, cont}, {7'h0, c});
    end
  endtask : chain
  // Each collected byte against the oldest expectation
  always @(got)
  begin
    #1;
    if (rst_n === 1'b1)
      check(gb, (q.size() > 0) ? q.pop_front() : 8'hXX);
  end
  initial
  begin
    #400000;
    failures++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {qe, fw, wen, pwr, srst, mrst, mwe, wlen, par, mwa, mwd} = 29'h0;
    repeat (12) @(posedge clk);
    check({dev_oe, dev_io}, 8'h0);
    check({5'h0, cont, dsel}, 8'h0);
    @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 1024; i++)
    begin
      @(negedge clk);
      {mwe, mwa, mwd} = {1'b1, 10'(i), 8'($random(seed))};
      mem[i] = mwd;
    end
    @(negedge clk);
    mwe = 1'b0;
    a = 24'($random(seed));
    for (int k = 0; k < 4; k++)
    begin
      @(negedge clk);
      {qe, fw} = {k > 1, k > 1};
      idle();
      mlfr_host_i.frame(ops[k], fw ? 4 : 1, a, 1, 0, 8'h00, 8, 0, 4);
      check({4'h0, dev_oe}, 8'h0);
      mlfr_host_i.stop();
    end
    @(negedge clk);
    {qe, fw} = 2'h2;
    idle();
    a = 24'($random(seed));
    note(a, 4, 24'hFFFFFF);
    mlfr_host_i.frame(8'h6B, 1, a, 1, 0, 8'h00, 8, 4, 4);
    mlfr_host_i.stop();
    chain(8'hBB, 1, 2, 0);
    chain(8'hEB, 1, 4, 4);
    for (int l = 0; l < 4; l++)
    begin
      @(negedge clk);
      {wen, wlen} = {1'b1, 2'(l)};
      idle();
      a = 24'($random(seed)) | ((24'h8 << l) - 24'h2);
      note(a, 5, (24'h8 << l) - 24'h1);
      mlfr_host_i.frame(8'hEB, 1, a, 4, 4, 8'h00, 4, 5, 4);
      mlfr_host_i.stop();
    end
    @(negedge clk);
    fw = 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      setp(2'(p), 1'b0);
      idle();
      n = (p == 0) ? 4 : (p == 1) ? 6 : 8;
      a = 24'($random(seed)) | 24'h3F;
      note(a, 3, 24'hFFFFFF);
      mlfr_host_i.frame(8'hEB, 4, a, 4, 4, 8'h00, n - 2, 3, 4);
      mlfr_host_i.stop();
    end
    setp(2'h2, 1'b1);
    idle();
    chain(8'hEB, 4, 4, 2);
    @(negedge clk);
    fw = 1'b0;
    idle();
    a = 24'($random(seed));
    note(a, 2, 24'hFFFFFF);
    mlfr_host_i.frame(8'hBB, 1, a, 2, 2, 8'hA0, 0, 2, 2);
    mlfr_host_i.stop();
    @(negedge clk);
    mrst = 1'b1;
    @(negedge clk);
    mrst = 1'b0;
    mlfr_host_i.frame(8'h00, 0, a, 4, 0, 8'h00, 0, 0, 4);
    mlfr_host_i.stop();
    repeat (8) @(negedge clk);
    check({7'h0, cont}, 8'h0);
    a = 24'($random(seed));
    note(a, 2, 24'hFFFFFF);
    mlfr_host_i.frame(8'hBB, 1, a, 2, 2, 8'h00, 0, 2, 2);
    mlfr_host_i.stop();
    check(8'(q.size()), 8'h0);
    give_verdict();
  end
endmodule : mlfr_engine_test
`default_nettype wire
